/* File: verilog/lbc_pkg.sv */
// Shared constants and carrier types for the loopback code 4 status block
package lbc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [15:0] LBC_STATUS_OFS = 16'h0B1E;
	localparam logic [15:0] LBC_ENABLE_OFS = 16'h0B1F;
	localparam int LBC_CHAN_LSB = 12;
	localparam int LBC_ADDR_W = 16;
	localparam int LBC_DATA_W = 8;

	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int LBC_ACT_STATE_BIT = 3;
	localparam int LBC_DEACT_STATE_BIT = 2;
	localparam int LBC_ACT_FLAG_BIT = 1;
	localparam int LBC_DEACT_FLAG_BIT = 0;

	// ----------------------------------------
	// Enable register fields
	// ----------------------------------------
	localparam int LBC_ACT_EN_BIT = 1;
	localparam int LBC_DEACT_EN_BIT = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] LBC_STATUS_RST = 8'h00;
	localparam logic [1:0] LBC_ENABLE_RST = 2'h0;
	localparam logic [1:0] LBC_FLAG_RST = 2'h0;
	localparam logic [1:0] LBC_DET_RST = 2'h0;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [LBC_ADDR_W-1:0] addr;
		logic [LBC_DATA_W-1:0] wrData;
		logic wr;
		logic rd;
	} lbc_bus_req_t;

	// Index 1 is activation, index 0 is deactivation
	typedef struct packed {
		logic [1:0] detect;
		logic actDetectEnable;
	} lbc_detect_in_t;

endpackage : lbc_pkg

/* File: verilog/lbc_change_det.sv */
// Level register and change detector for the code detection levels
module lbc_change_det #(
	parameter int WIDTH = 2
) (
	input wire logic coreClk, // Core clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic [WIDTH-1:0] level, // Present detection levels
	output logic [WIDTH-1:0] levelQ, // Registered levels
	output logic [WIDTH-1:0] change // High in a cycle where a level differs from levelQ
);
	import lbc_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] lvl;
	} lbc_det_state_t;

	lbc_det_state_t state_reg;
	lbc_det_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.lvl = level;
	end

	always_ff @(posedge coreClk) begin
		if (reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign levelQ = state_reg.lvl;

	// One pulse per start or stop of detection
	for (genvar i = 0; i < WIDTH; i++) begin : g_chg
		assign change[i] = level[i] ^ state_reg.lvl[i];
	end

endmodule : lbc_change_det

/* File: verilog/lbc_status_irq.sv */
// Loopback code 4 status, change flags and interrupt enable registers
//
// The implementer's own choice: the strobed register port.
module lbc_status_irq #(
	parameter logic [3:0] CHANNEL = 4'h0
) (
	input wire logic coreClk, // Core clock, 250 MHz
	input wire logic reset, // Synchronous reset, active high
	input wire lbc_pkg::lbc_bus_req_t busReq, // Register request
	output logic [lbc_pkg::LBC_DATA_W-1:0] rdData, // Read data, cycle after read
	input wire lbc_pkg::lbc_detect_in_t detIn, // Detector levels and enable
	output logic irq // Level interrupt, active high
);
	import lbc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] flag;
		logic [1:0] irqEn;
		logic [LBC_DATA_W-1:0] rdData;
		logic irq;
	} lbc_state_t;

	lbc_state_t state_reg;
	lbc_state_t state_next;

	logic [1:0] detLevel;
	logic [1:0] detQ;
	logic [1:0] detChange;

	function automatic logic regHit(input logic [LBC_ADDR_W-1:0] a,
		input logic [LBC_ADDR_W-1:0] ofs);
		regHit = (a[LBC_ADDR_W-1:LBC_CHAN_LSB] == CHANNEL)
			&& (a[LBC_CHAN_LSB-1:0] == ofs[LBC_CHAN_LSB-1:0]);
	endfunction : regHit

	// ----------------------------------------
	// Detection levels
	// ----------------------------------------
	assign detLevel[1] = detIn.detect[1] & detIn.actDetectEnable;
	assign detLevel[0] = detIn.detect[0];

	lbc_change_det #(
		.WIDTH(2)
	) u_change (
		.coreClk(coreClk),
		.reset(reset),
		.level(detLevel),
		.levelQ(detQ),
		.change(detChange)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic stHit;
		logic enHit;
		logic [LBC_DATA_W-1:0] statusView;
		logic [1:0] clr;
		stHit = regHit(busReq.addr, LBC_STATUS_OFS);
		enHit = regHit(busReq.addr, LBC_ENABLE_OFS);
		statusView = LBC_STATUS_RST;
		statusView[LBC_ACT_STATE_BIT] = detLevel[1];
		statusView[LBC_DEACT_STATE_BIT] = detLevel[0];
		statusView[LBC_ACT_FLAG_BIT] = state_reg.flag[1];
		statusView[LBC_DEACT_FLAG_BIT] = state_reg.flag[0];
		state_next = state_reg;
		clr = 2'h0;
		if (busReq.rd && stHit) begin
			clr = 2'h3;
		end
		if (busReq.wr && stHit) begin
			clr = busReq.wrData[1:0];
		end
		// Set wins over clear
		state_next.flag = (state_reg.flag & ~clr) | detChange;
		if (busReq.wr && enHit) begin
			state_next.irqEn[1] = busReq.wrData[LBC_ACT_EN_BIT];
			state_next.irqEn[0] = busReq.wrData[LBC_DEACT_EN_BIT];
		end
		state_next.rdData = 8'h00;
		if (busReq.rd && stHit) begin
			state_next.rdData = statusView;
		end else if (busReq.rd && enHit) begin
			state_next.rdData = {6'h00, state_reg.irqEn};
		end
		state_next.irq = |(state_next.flag & state_next.irqEn);
	end

	always_ff @(posedge coreClk) begin
		if (reset) begin
			state_reg.flag <= LBC_FLAG_RST;
			state_reg.irqEn <= LBC_ENABLE_RST;
			state_reg.rdData <= LBC_STATUS_RST;
			state_reg.irq <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdData = state_reg.rdData;
	assign irq = state_reg.irq;

endmodule : lbc_status_irq

/* File: tb/lbc_chk_checker.sv */
// Checker for the loopback code 4 status block
module lbc_chk (
	input wire logic coreClk, // Clock
	input wire logic reset, // Reset
	input wire lbc_pkg::lbc_bus_req_t busReq, // Request
	input wire logic [7:0] rdData, // Read data
	input wire lbc_pkg::lbc_detect_in_t detIn, // Detector
	input wire logic irq // Interrupt
);
	import lbc_pkg::*;
	logic [1:0] lvl_reg, en_reg, cur, chg;
	logic rs;
	assign cur = {detIn.detect[1] & detIn.actDetectEnable, detIn.detect[0]};
	assign chg = cur ^ lvl_reg;
	assign rs = busReq.rd && busReq.addr == LBC_STATUS_OFS;
	always_ff @(posedge coreClk) begin
		lvl_reg <= reset ? 2'h0 : cur;
		if (reset)
			en_reg <= 2'h0;
		else if (busReq.wr && busReq.addr == LBC_ENABLE_OFS)
			en_reg <= busReq.wrData[1:0];
	end
	default clocking @(posedge coreClk); endclocking
	default disable iff (reset);
	a_act_state: assert property (rs |=> rdData[3] == $past(cur[1]))
		else $error("act state");
	a_deact_state: assert property (rs |=> rdData[2] == $past(cur[0]))
		else $error("deact state");
	a_act_flag: assert property (chg[1] ##1 !rs && !busReq.wr ##1 rs |=> rdData[1])
		else $error("act flag");
	a_deact_flag: assert property (chg[0] ##1 !rs && !busReq.wr ##1 rs |=> rdData[0])
		else $error("deact flag");
	a_flag_clear: assert property (rs && chg == 2'h0 ##1 rs |=> rdData[1:0] == 2'h0)
		else $error("flag clear");
	a_resv_zero: assert property (rdData[7:4] == 4'h0)
		else $error("reserved bits");
	a_irq_set: assert property (|(chg & en_reg) |=> irq)
		else $error("irq missing");
	a_irq_quiet: assert property (en_reg == 2'h0 && $past(en_reg) == 2'h0 |-> !irq)
		else $error("irq masked");
	a_same_cycle: assert property (rs && chg[0] ##1 rs |=> rdData[0])
		else $error("event lost");
endmodule : lbc_chk
bind lbc_status_irq lbc_chk i_chk (.coreClk, .reset, .busReq, .rdData, .detIn, .irq);

/* File: tb/lbc_status_irq_tb.sv */
// Self-checking bench for the loopback code 4 status block
module lbc_status_irq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lbc_pkg::*;
	logic coreClk = 0, reset = 1, irq;
	lbc_bus_req_t busReq = '0;
	lbc_detect_in_t detIn = '0;
	logic [7:0] rdData;
	int errCount = 0, cmpCount = 0, cyc = 0;
	always #2 coreClk = ~coreClk;
	lbc_status_irq i_dut (.coreClk, .reset, .busReq, .rdData, .detIn, .irq);
	task automatic giveVerdict;
		$display("compares %0d mismatches %0d", cmpCount, errCount);
		if (errCount == 0 && cmpCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : giveVerdict
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errCount++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge coreClk);
		busReq <= '0;
		@(posedge coreClk);
	endtask : wr
	// Two back-to-back reads when two is set
	task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1 = 0,
		input bit two = 0);
		busReq <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge coreClk);
		if (!two)
			busReq <= '0;
		@(posedge coreClk);
		check(rdData, e0);
		if (two) begin
			busReq <= '0;
			@(posedge coreClk);
			check(rdData, e1);
		end
	endtask : rd
	always @(posedge coreClk) begin
		cyc++;
		if (cyc == 1000) begin
			errCount++;
			giveVerdict();
		end
	end
	initial begin
		repeat (3) @(posedge coreClk);
		reset <= 0;
		rd(LBC_STATUS_OFS, 8'h00);
		rd(LBC_ENABLE_OFS, 8'h00);
		$display("reset values done");
		wr(LBC_ENABLE_OFS, 8'h01);
		detIn <= '{2'b01, 1'b1};
		repeat (2) @(posedge coreClk);
		check({7'h0, irq}, 8'h01);
		rd(LBC_STATUS_OFS, 8'h05, 8'h04, 1);
		check({7'h0, irq}, 8'h00);
		$display("deact change done");
		detIn <= '{2'b11, 1'b0};
		rd(LBC_STATUS_OFS, 8'h04);
		detIn.actDetectEnable <= 1'b1;
		repeat (2) @(posedge coreClk);
		check({7'h0, irq}, 8'h00);
		rd(LBC_STATUS_OFS, 8'h0E);
		detIn.detect <= 2'b10;
		rd(LBC_STATUS_OFS, 8'h08, 8'h09, 1);
		$display("act change done");
		wr(LBC_ENABLE_OFS, 8'h03);
		detIn.actDetectEnable <= 1'b0;
		repeat (2) @(posedge coreClk);
		check({7'h0, irq}, 8'h01);
		wr(LBC_ENABLE_OFS, 8'h00);
		@(posedge coreClk);
		check({7'h0, irq}, 8'h00);
		wr(LBC_STATUS_OFS, 8'hF2);
		rd(LBC_STATUS_OFS, 8'h00);
		wr(16'h1B1F, 8'h03);
		rd(16'h1B1E, 8'h00);
		rd(LBC_ENABLE_OFS, 8'h00);
		$display("mask and decode done");
		giveVerdict();
	end
endmodule : lbc_status_irq_tb
